//--- core/bdcvm_regs.sv
// design: serial slave and config, verify and mask registers of the bridge driver
// ***********************************************
// register bank
// ***********************************************
module bdcvm_regs
  import bdcvm_pkg::*;
(
  // core clock and reset
  input  wire logic           clock_i,
  input  wire logic           rst_i,
  // serial link
  input  wire logic           sclk_i,
  input  wire logic           cs_n_i,
  input  wire logic           sdi_i,
  output logic                sdo_o,
  output logic                sdo_oe_o,
  // configuration fields
  output bdcvm_cfg4_type      cfg_open_load_regulator_o,
  output bdcvm_cfg5_type      cfg_sense_amplifier_o,
  // verification commands
  output logic [7:0]          verify_monitor_o,
  output bdcvm_vbr_type       verify_bridge_o,
  output logic [7:0]          verify_start_o,
  // verification outcomes from the monitors
  input  wire logic [4:0]     connect_result_i,
  input  wire logic [2:0]     state_result_i,
  // fault masks
  output logic [5:0]          mask_gate_o,
  output logic [7:0]          mask_supply_drain_o,
  // serial status
  output logic                serial_error_o
);

  // ***********************************************
  // link domain: shift in on rising serial clock
  // ***********************************************
  logic [15:0] rx_sr_r;
  logic [4:0]  bit_cnt_r;
  logic [4:0]  bit_cnt_nxt;
  logic        armed_r;
  logic        tx_bit_r;
  logic [15:0] resp_r;
  logic        frame_tog_r;

  // counter saturates so a long frame still reads as wrong length
  assign bit_cnt_nxt = armed_r ? 5'h01 : ((bit_cnt_r == BITS_SAT) ? BITS_SAT : bit_cnt_r + 5'h01);

  // armed is set by the frame's own select, so no serial edge is needed outside a frame
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      armed_r <= 1'b1;
    end else begin
      armed_r <= 1'b0;
    end
  end

  // word and count stay still after the frame, the core reads them then
  always_ff @(posedge sclk_i) begin
    rx_sr_r   <= {rx_sr_r[14:0], sdi_i};
    bit_cnt_r <= bit_cnt_nxt;
  end

  // one toggle per frame that saw a serial edge, so a bare select pulse cannot replay the old word
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_tog_r <= 1'b0;
    end else begin
      frame_tog_r <= frame_tog_r ^ armed_r;
    end
  end

  // next output bit changes on the falling edge, master samples on rising
  wire [3:0] tx_idx = 4'hf - bit_cnt_r[3:0];
  always_ff @(negedge sclk_i) begin
    tx_bit_r <= (bit_cnt_r >= BITS_FRAME) ? 1'b0 : resp_r[tx_idx];
  end

  // first bit is shown at select, before any serial edge
  assign sdo_o    = cs_n_i ? 1'b0 : (armed_r ? resp_r[15] : tx_bit_r);
  assign sdo_oe_o = ~cs_n_i;

  // ***********************************************
  // crossing: select level into the core clock
  // ***********************************************
  logic cs_meta_r;
  logic cs_sync_r;
  logic cs_last_r;
  logic tog_meta_r;
  logic tog_sync_r;
  logic tog_seen_r;

  // only the second stage and later are looked at
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_last_r <= 1'b1;
      tog_meta_r <= 1'b0;
      tog_sync_r <= 1'b0;
    end else begin
      cs_meta_r <= cs_n_i;
      cs_sync_r <= cs_meta_r;
      cs_last_r <= cs_sync_r;
      tog_meta_r <= frame_tog_r;
      tog_sync_r <= tog_meta_r;
    end
  end

  // frame end: rx word and count are quiet once select is high
  wire        frame_end = cs_sync_r & ~cs_last_r;
  wire [15:0] rx_word   = rx_sr_r;
  wire        len_ok    = (bit_cnt_r == BITS_FRAME);
  wire        par_ok    = ^rx_word;
  wire        fresh     = tog_sync_r ^ tog_seen_r;
  wire        good      = frame_end & len_ok & par_ok & fresh;
  wire [3:0]  adr       = rx_word[ADDR_MSB:ADDR_LSB];
  wire        wr_req    = good & rx_word[WR_POS];
  wire [9:0]  wdata     = rx_word[DATA_MSB:DATA_LSB];

  // ***********************************************
  // outcome inputs come from analog monitors: two flops
  // ***********************************************
  logic [4:0] conn_meta_r;
  logic [4:0] conn_sync_r;
  logic [2:0] state_meta_r;
  logic [2:0] state_sync_r;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      conn_meta_r  <= 5'h00;
      conn_sync_r  <= 5'h00;
      state_meta_r <= 3'h0;
      state_sync_r <= 3'h0;
    end else begin
      conn_meta_r  <= connect_result_i;
      conn_sync_r  <= conn_meta_r;
      state_meta_r <= state_result_i;
      state_sync_r <= state_meta_r;
    end
  end

  // ***********************************************
  // register write decode
  // ***********************************************
  wire we_cfg4 = wr_req & (adr == ADR_CFG_OPEN_LOAD_REGULATOR);
  wire we_cfg5 = wr_req & (adr == ADR_CFG_SENSE_AMPLIFIER);
  wire we_vmon = wr_req & (adr == ADR_VERIFY_MONITOR_COMMAND);
  wire we_vbr  = wr_req & (adr == ADR_VERIFY_BRIDGE_COMMAND);
  wire we_msk0 = wr_req & (adr == ADR_FAULT_MASK_GATE);
  wire we_msk1 = wr_req & (adr == ADR_FAULT_MASK_SUPPLY_DRAIN);

  logic [9:0] cfg4_r;
  logic [9:0] cfg5_r;
  logic [9:0] vmon_r;
  logic [9:0] vbr_r;
  logic [9:0] res0_r;
  logic [9:0] res1_r;
  logic [9:0] msk0_r;
  logic [9:0] msk1_r;
  logic [7:0] start_r;
  logic       serr_r;

  // unimplemented bits are masked away so they always read zero
  wire [9:0] cfg4_nxt = we_cfg4 ? (wdata & CFG4_BITS) : cfg4_r;
  wire [9:0] cfg5_nxt = we_cfg5 ? (wdata & CFG5_BITS) : cfg5_r;
  wire [9:0] vmon_nxt = we_vmon ? (wdata & VMON_BITS) : vmon_r;
  wire [9:0] vbr_nxt  = we_vbr  ? (wdata & VBR_BITS)  : vbr_r;
  wire [9:0] msk0_nxt = we_msk0 ? (wdata & MSK0_BITS) : msk0_r;
  wire [9:0] msk1_nxt = we_msk1 ? (wdata & MSK1_BITS) : msk1_r;

  // result registers follow the monitors only, never the bus
  wire [9:0] res0_nxt = {4'h0, conn_sync_r[4:2], 1'b0, conn_sync_r[1:0]} & RES0_BITS;
  wire [9:0] res1_nxt = {5'h00, state_sync_r[2:1], 2'h0, state_sync_r[0]} & RES1_BITS;

  // a write of one to a check bit launches it once
  wire [7:0] start_nxt = we_vbr ? ({wdata[8:5], wdata[3:0]} & VBR_START) : 8'h00;

  // error reflects the last frame only
  wire serr_nxt = frame_end ? ~good : serr_r;

  // frame toggle consumed at each frame end
  wire tog_seen_nxt = frame_end ? tog_sync_r : tog_seen_r;

  // ***********************************************
  // register storage
  // ***********************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg4_r <= CFG4_RST;
      cfg5_r <= CFG5_RST;
      vmon_r <= ZERO_RST;
      vbr_r  <= ZERO_RST;
      msk0_r <= ZERO_RST;
      msk1_r <= ZERO_RST;
    end else begin
      cfg4_r <= cfg4_nxt;
      cfg5_r <= cfg5_nxt;
      vmon_r <= vmon_nxt;
      vbr_r  <= vbr_nxt;
      msk0_r <= msk0_nxt;
      msk1_r <= msk1_nxt;
    end
  end

  // results, start pulses and error flag
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      res0_r  <= ZERO_RST;
      res1_r  <= ZERO_RST;
      start_r <= 8'h00;
      serr_r  <= 1'b0;
      tog_seen_r <= 1'b0;
    end else begin
      res0_r  <= res0_nxt;
      res1_r  <= res1_nxt;
      start_r <= start_nxt;
      serr_r  <= serr_nxt;
      tog_seen_r <= tog_seen_nxt;
    end
  end

  // ***********************************************
  // read path and response word
  // ***********************************************
  // answer carries the register just addressed, shifted out in the next frame
  wire [9:0] rdata =
    (adr == ADR_CFG_OPEN_LOAD_REGULATOR) ? cfg4_r :
    (adr == ADR_CFG_SENSE_AMPLIFIER)     ? cfg5_r :
    (adr == ADR_VERIFY_MONITOR_COMMAND)  ? vmon_r :
    (adr == ADR_VERIFY_BRIDGE_COMMAND)   ? vbr_r  :
    (adr == ADR_VERIFY_CONNECT_RESULT)   ? res0_r :
    (adr == ADR_VERIFY_STATE_RESULT)     ? res1_r :
    (adr == ADR_FAULT_MASK_GATE)         ? msk0_r :
    (adr == ADR_FAULT_MASK_SUPPLY_DRAIN) ? msk1_r : 10'h000;
  wire [3:0]  resp_adr  = good ? adr : 4'h0;
  wire [9:0]  resp_dat  = good ? rdata : 10'h000;
  wire [14:0] resp_body = {resp_adr, 1'b0, resp_dat};
  wire [15:0] resp_nxt  = frame_end ? {resp_body, ~(^resp_body)} : resp_r;

  // held still between frames, so the link side reads it quasi-static
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      resp_r <= 16'h0001;
    end else begin
      resp_r <= resp_nxt;
    end
  end

  // ***********************************************
  // field outputs
  // ***********************************************
  assign cfg_open_load_regulator_o = bdcvm_cfg4_type'(cfg4_r);
  assign cfg_sense_amplifier_o     = bdcvm_cfg5_type'(cfg5_r);
  assign verify_monitor_o          = vmon_r[9:2];
  assign verify_bridge_o           = bdcvm_vbr_type'(vbr_r);
  assign verify_start_o            = start_r;
  assign mask_gate_o               = {msk0_r[7:6], msk0_r[3:0]};
  assign mask_supply_drain_o       = {msk1_r[9:6], msk1_r[3:0]};
  assign serial_error_o            = serr_r;

  // ***********************************************
  // checks
  // ***********************************************
  resp_parity_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (^resp_r) == 1'b1) else $error("response word parity not odd");

  bad_nowrite_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (frame_end && !par_ok) |=> ($stable(cfg4_r) && $stable(msk0_r) && $stable(vbr_r)))
    else $error("bad parity frame changed a register");

  reset_default_a : assert property (@(posedge clock_i) disable iff (rst_i)
    $past(rst_i) |-> (cfg4_r == 10'h060 && cfg5_r == 10'h0f5 && vmon_r == 10'h000 && msk1_r == 10'h000))
    else $error("register default wrong after reset");

  cfg_write_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (good && rx_word[11] && rx_word[15:12] == 4'h5) |=> cfg5_r == ($past(wdata) & 10'h1f7))
    else $error("sense amplifier write not stored");

  start_once_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (we_vbr && wdata[0]) |=> (verify_start_o[0] ##1 !verify_start_o[0]))
    else $error("check start pulse not exactly one cycle");

  start_cause_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (verify_start_o != 8'h00) |-> $past(we_vbr))
    else $error("check start without a write");

  serr_set_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (frame_end && !len_ok) |=> serial_error_o)
    else $error("serial error not raised on wrong length");

  serr_hold_a : assert property (@(posedge clock_i) disable iff (rst_i)
    !frame_end |=> $stable(serial_error_o))
    else $error("serial error changed outside a frame end");

  serr_clear_a : assert property (@(posedge clock_i) disable iff (rst_i)
    good |=> !serial_error_o)
    else $error("serial error left set after good frame");

  ro_ignore_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (wr_req && adr == 4'h9) |=> ({res1_r[4:3], res1_r[0]} == $past(state_sync_r)
      && (res1_r & ~10'h019) == 10'h000))
    else $error("write reached a result register");

  state_zero_a : assert property (@(posedge clock_i) disable iff (rst_i)
    $past(rst_i) |-> res1_r == 10'h000)
    else $error("state result not zero after reset");

  mask_bits_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (msk0_r & ~10'h0cf) == 10'h000 && (msk1_r & ~10'h3cf) == 10'h000)
    else $error("reserved mask bit set");

endmodule // bdcvm_regs

//--- shared/bdcvm_pkg.sv
// package: map, layouts and reset values of the config, verify and mask bank
package bdcvm_pkg;

  // ***********************************************
  // serial word layout
  // ***********************************************
  localparam int unsigned WORD_BITS   = 16;
  localparam int unsigned ADDR_MSB    = 15;
  localparam int unsigned ADDR_LSB    = 12;
  localparam int unsigned WR_POS      = 11;
  localparam int unsigned DATA_MSB    = 10;
  localparam int unsigned DATA_LSB    = 1;
  localparam int unsigned DATA_BITS   = 10;
  localparam logic [4:0]  BITS_FRAME  = 5'h10;
  localparam logic [4:0]  BITS_SAT    = 5'h11;

  // ***********************************************
  // register addresses
  // ***********************************************
  localparam logic [3:0] ADR_CFG_OPEN_LOAD_REGULATOR = 4'h4;
  localparam logic [3:0] ADR_CFG_SENSE_AMPLIFIER     = 4'h5;
  localparam logic [3:0] ADR_VERIFY_MONITOR_COMMAND  = 4'h6;
  localparam logic [3:0] ADR_VERIFY_BRIDGE_COMMAND   = 4'h7;
  localparam logic [3:0] ADR_VERIFY_CONNECT_RESULT   = 4'h8;
  localparam logic [3:0] ADR_VERIFY_STATE_RESULT     = 4'h9;
  localparam logic [3:0] ADR_FAULT_MASK_GATE         = 4'ha;
  localparam logic [3:0] ADR_FAULT_MASK_SUPPLY_DRAIN = 4'hb;

  // ***********************************************
  // implemented bits (data bit i sits at word bit i+1) and reset values
  // ***********************************************
  localparam logic [9:0] CFG4_BITS = 10'h3ff;
  localparam logic [9:0] CFG5_BITS = 10'h1f7;
  localparam logic [9:0] VMON_BITS = 10'h3fc;
  localparam logic [9:0] VBR_BITS  = 10'h3ef;
  localparam logic [9:0] RES0_BITS = 10'h03b;
  localparam logic [9:0] RES1_BITS = 10'h019;
  localparam logic [9:0] MSK0_BITS = 10'h0cf;
  localparam logic [9:0] MSK1_BITS = 10'h3cf;
  localparam logic [9:0] CFG4_RST  = 10'h060;
  localparam logic [9:0] CFG5_RST  = 10'h0f5;
  localparam logic [9:0] ZERO_RST  = 10'h000;
  localparam logic [7:0] VBR_START = 8'hff;

  // ***********************************************
  // field carriers, laid out as data bits 9..0
  // ***********************************************
  typedef struct packed {
    logic       on_open_load_enable;
    logic       enable_watchdog_on;
    logic       off_test_current_sel;
    logic       regulator_level_sel;
    logic [5:0] phase_threshold_code;
  } bdcvm_cfg4_type;

  typedef struct packed {
    logic       spare_hi;
    logic       off_open_load_disable;
    logic [3:0] amp_offset_code;
    logic       spare_lo;
    logic [2:0] amp_gain_code;
  } bdcvm_cfg5_type;

  typedef struct packed {
    logic       open_load_phase_sel;
    logic       chk_phase_connect_high;
    logic       chk_phase_connect_low;
    logic       chk_drain_source_over;
    logic       chk_overcurrent;
    logic       spare;
    logic       chk_gate_source_under;
    logic       chk_on_open_load;
    logic       chk_off_load_source;
    logic       chk_off_load_sink;
  } bdcvm_vbr_type;

endpackage : bdcvm_pkg

//--- sim/bdcvm_master.sv
// partner: serial master model that frames words for the register bank
module bdcvm_master (
  // serial link towards the device
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 40;

  // link idles with the clock parked low and the frame deselected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // ***********************************************
  // one frame, msb first; a short count only when a scenario asks for it
  // ***********************************************
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    #13;
    cs_n_o = 1'b0;
    for (int k = 0; k < nbits; k++) begin
      sdi_o = w[15-k];
      #HALF;
      sclk_o = 1'b1;
      rx[15-k] = sdo_i;
      #HALF;
      sclk_o = 1'b0;
    end
    #HALF;
    cs_n_o = 1'b1;
    sdi_o  = ~sdi_o; // idle line never shows the last bit
    #100;            // gap well above the three core cycles needed
  endtask
endmodule // bdcvm_master

//--- sim/tb_top.sv
// testbench: serial access to the config, verify and mask bank
module tb_top
  import bdcvm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ***********************************************
  // signals and instances
  // ***********************************************
  logic           clock_i;
  logic           rst_i;
  logic           sclk;
  logic           cs_n;
  logic           sdi;
  logic [4:0]     conn;
  logic [2:0]     state;
  wire logic      sdo;
  wire logic      sdo_line;
  logic           sdo_oe;
  logic           serr;
  bdcvm_cfg4_type cfg4;
  bdcvm_cfg5_type cfg5;
  bdcvm_vbr_type  bridge_supply_disconnected;
  logic [7:0]     vmon;
  logic [7:0]     vstart;
  logic [5:0]     mgate;
  logic [7:0]     msd;
  logic [15:0]    rx;
  logic [7:0]     start_acc;
  logic [15:0]    start_cnt;
  int             fail_count = 0;
  int             compares = 0;

  bdcvm_regs u_bdcvm_regs (.clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .cfg_open_load_regulator_o(cfg4), .cfg_sense_amplifier_o(cfg5),
    .verify_monitor_o(vmon), .verify_bridge_o(bridge_supply_disconnected), .verify_start_o(vstart), .connect_result_i(conn),
    .state_result_i(state), .mask_gate_o(mgate), .mask_supply_drain_o(msd), .serial_error_o(serr));
  bdcvm_master u_bdcvm_master (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_line));

  // a released data line floats up to its pull-up, so a dead enable shows in every read
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // start pulses are gathered so a stray or doubled pulse shows up
  always @(posedge clock_i) begin
    if (vstart !== 8'h00) begin
      start_acc = start_acc | vstart;
      start_cnt = start_cnt + 16'h1;
    end
  end

  // ***********************************************
  // helpers
  // ***********************************************
  function automatic logic [15:0] mk(logic [3:0] a, logic w, logic [9:0] d);
    return {a, w, d, ~^{a, w, d}};
  endfunction

  function automatic logic [9:0] rv(logic [3:0] a);
    return (a == 4'h4) ? 10'h060 : (a == 4'h5) ? 10'h0f5 : 10'h000;
  endfunction

  function automatic logic [9:0] bits_of(logic [3:0] a);
    case (a)
      4'h4: return 10'h3ff;
      4'h5: return 10'h1f7;
      4'h6: return 10'h3fc;
      4'h7: return 10'h3ef;
      4'ha: return 10'h0cf;
      4'hb: return 10'h3cf;
      default: return 10'h000;
    endcase
  endfunction

  // field view at the ports, and what a written word should put there
  function automatic logic [15:0] port_of(logic [3:0] a);
    case (a)
      4'h4: return {6'h0, cfg4};
      4'h5: return {6'h0, cfg5};
      4'h6: return {8'h0, vmon};
      4'h7: return {6'h0, bridge_supply_disconnected};
      4'ha: return {10'h0, mgate};
      default: return {8'h0, msd};
    endcase
  endfunction

  function automatic logic [15:0] pexp(logic [3:0] a, logic [9:0] d);
    case (a)
      4'h6: return {8'h0, d[9:2]};
      4'ha: return {10'h0, d[7:6], d[3:0]};
      4'hb: return {8'h0, d[9:6], d[3:0]};
      default: return {6'h0, d & bits_of(a)};
    endcase
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic frame(input logic [15:0] w, input int n);
    @(posedge clock_i);
    #1;
    u_bdcvm_master.xfer(w, n, rx);
  endtask

  task automatic finish_test();
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_reset();
    chk({6'h0, cfg4}, 16'h0060);
    chk({6'h0, cfg5}, 16'h00f5);
    chk({vmon, mgate, serr, 1'b0}, 16'h0000);
    chk({6'h0, bridge_supply_disconnected}, 16'h0000);
    chk({8'h0, msd}, 16'h0000);
    for (int a = 4; a < 14; a++) begin
      frame(mk(4'(a), 1'b0, 10'h000), 16);
      if (a > 4) chk(rx, mk(4'(a - 1), 1'b0, rv(4'(a - 1))));
    end
  endtask

  task automatic t_rw();
    logic [3:0] al[6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb};
    logic [9:0] dl[4] = '{10'h3ff, 10'h000, 10'h2a5, 10'h15a};
    logic [7:0] st;
    foreach (al[i]) foreach (dl[j]) begin
      start_acc = 8'h00;
      start_cnt = 16'h0;
      frame(mk(al[i], 1'b1, dl[j]), 16);
      frame(mk(al[i], 1'b0, 10'h000), 16);
      // the answer to a frame is shifted out during the frame after it
      frame(mk(al[i], 1'b0, 10'h000), 16);
      chk(rx, mk(al[i], 1'b0, dl[j] & bits_of(al[i])));
      chk(port_of(al[i]), pexp(al[i], dl[j]));
      if (al[i] == 4'h7) begin
        st = {dl[j][8:5], dl[j][3:0]};
        chk({8'h0, start_acc}, {8'h0, st});
        chk(start_cnt, (st != 8'h00) ? 16'h1 : 16'h0);
      end
    end
  endtask

  task automatic t_ro(input logic [4:0] c, input logic [2:0] s);
    @(posedge clock_i);
    #1;
    conn  = c;
    state = s;
    repeat (10) @(posedge clock_i);
    frame(mk(4'h8, 1'b1, 10'h3ff), 16);
    frame(mk(4'h9, 1'b1, 10'h3ff), 16);
    chk(rx, mk(4'h8, 1'b0, {4'h0, c[4:2], 1'b0, c[1:0]}));
    frame(mk(4'h0, 1'b0, 10'h000), 16);
    chk(rx, mk(4'h9, 1'b0, {5'h0, s[2:1], 2'b00, s[0]}));
  endtask

  task automatic t_err(input logic [15:0] w, input int n);
    frame(w, n);
    chk({15'h0, serr}, 16'h0001);
    chk({6'h0, cfg4}, 16'h015a);
    frame(mk(4'h4, 1'b0, 10'h000), 16);
    chk(rx, 16'h0001);
    chk({15'h0, serr}, 16'h0000);
  endtask

  initial begin
    rst_i = 1'b1;
    conn  = 5'h00;
    state = 3'h0;
    start_acc = 8'h00;
    start_cnt = 16'h0;
    repeat (5) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    repeat (8) @(posedge clock_i);
    t_reset();
    t_rw();
    t_ro(5'h1f, 3'h7);
    t_ro(5'h15, 3'h5);
    t_err(mk(4'h4, 1'b1, 10'h3ff) ^ 16'h0001, 16);
    t_err(mk(4'h4, 1'b1, 10'h3ff), 15);
    finish_test();
  end

  // a hang is cut well after the roughly 130 us the frames need
  initial begin
    #300000;
    fail_count++;
    finish_test();
  end
endmodule // tb_top
